// ---- cpu_core_model.sv ----
// CPU core stand-in that walks instruction boundaries and accepts offered vectors.
`timescale 1ns/100ps
module cpu_core_model
(
    // Clock and reset.
    input  wire logic                   mclk,
    input  wire logic                   rst,
    // Bench control: boundary enable, {idle, ret_nmi, ret_maskable}, trap level.
    input  wire logic                   go,
    input  wire logic [2:0]             ctl,
    input  wire logic                   trap,
    // Controller link and what was taken from it.
    input  wire irq_ctrl_pkg::cpu_req_t req_in,
    output irq_ctrl_pkg::cpu_rsp_t      rsp,
    output logic [15:0]                 last_vec,
    output int                          acc_n
);
    import irq_ctrl_pkg::*;
    logic ins; // Instruction boundary strobe.
    logic acc; // Accept strobe.
    // Boundaries only while the link is quiet, so a frozen winner is never disturbed.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            ins      <= 1'b0;
            acc      <= 1'b0;
            last_vec <= 16'h0000;
            acc_n    <= 0;
        end
        else
        begin
            ins <= go && !req_in.req && !ins && !acc;
            acc <= req_in.req && !acc;
            if (req_in.req && !acc)
            begin
                last_vec <= req_in.vector;
                acc_n    <= acc_n + 1;
            end
        end
    end
    // Return and idle strobes come straight from the bench.
    assign rsp = '{ins, acc, ctl[0], ctl[1], ctl[2], trap};
endmodule : cpu_core_model

// ---- irq_controller.sv ----
// Prioritized vectored interrupt controller with Avalon-MM register access.
`timescale 1ns/100ps
`include "irq_ctrl_consts.svh"
module irq_controller
#(
    parameter int MCYC_CLKS   = `IRQ_MCYC_CLKS,   // Clocks per machine cycle.
    parameter int ACCEPT_MCYC = `IRQ_ACCEPT_MCYC  // Machine cycles per acceptance.
)
(
    // Clock and reset.
    input  wire logic                  mclk,
    input  wire logic                  rst,
    // Avalon-MM slave.
    input  wire logic [7:0]            address,
    input  wire logic                  read,
    input  wire logic                  write,
    input  wire logic [31:0]           writedata,
    input  wire logic [3:0]            byteenable,
    output logic [31:0]                readdata,
    output logic                       waitrequest,
    // Source events, one-cycle pulses on mclk, bit n is latch n.
    input  wire logic [15:2]           src_pulse,
    input  wire logic                  ext0_gate_bit,
    // CPU core link.
    input  wire irq_ctrl_pkg::cpu_rsp_t cpu_rsp,
    output irq_ctrl_pkg::cpu_req_t     cpu_req,
    output logic                       idle_state
);
    import irq_ctrl_pkg::*;

    // -----------------------------------------------------------------------
    // State.
    // -----------------------------------------------------------------------
    logic [15:2] pending_latch;       // Request latches.
    logic [15:2] next_pending_latch;
    logic        master_enable_flag;  // Global maskable enable.
    logic        next_master_enable_flag;
    logic [15:4] source_enable_flag;  // Per-source enables.
    logic [15:4] next_source_enable_flag;
    logic        boot_pending;        // Reset vector still to be offered.
    logic        next_boot_pending;
    logic        nmi_active;          // A pseudo non-maskable service runs.
    logic        next_nmi_active;
    logic        imf_saved;           // Master enable at pseudo NMI entry.
    logic        next_imf_saved;
    seq_state_t  state;               // Acceptance sequencer.
    seq_state_t  next_state;
    logic [7:0]  mdiv;                // Clock count within a machine cycle.
    logic [7:0]  next_mdiv;
    logic [7:0]  mcount;              // Machine cycles spent in acceptance.
    logic [7:0]  next_mcount;
    cpu_req_t    next_cpu_req;
    logic        next_idle_state;
    logic        next_waitrequest;
    logic [31:0] next_readdata;

    // -----------------------------------------------------------------------
    // Decoded bus and selection signals.
    // -----------------------------------------------------------------------
    logic [5:0]  idx;         // Register index from the byte address.
    logic        wr_take;     // Write completes this edge, low lane enabled.
    logic [15:0] pend_all;    // Boot, trap and latches as one vector.
    logic [15:0] enables;     // Enable word as software sees it.
    logic        any_win;     // Some request is eligible.
    logic [3:0]  win_level;   // Highest priority eligible level.
    logic        wake;        // Idle release condition.
    logic        mtick;       // Last clock of a machine cycle.
    logic        take_accept; // CPU accepted the offered request.

    assign idx         = address[7:2];
    assign wr_take     = write & ~waitrequest & byteenable[0];
    assign pend_all    = {pending_latch, cpu_rsp.sw_trap, boot_pending};
    assign enables     = {source_enable_flag, 3'b000, master_enable_flag};
    assign mtick       = (mdiv == 8'(MCYC_CLKS - 1));
    assign take_accept = (state == ST_OFFER) & cpu_rsp.accept;

    // Gating and priority selection.
    irq_priority_pick u_pick
    (
        .pend_all      (pend_all),
        .enables       (enables),
        .ext0_gate_bit (ext0_gate_bit),
        .nmi_active    (nmi_active),
        .any_win       (any_win),
        .win_level     (win_level),
        .wake          (wake)
    );

    // -----------------------------------------------------------------------
    // Bus slave: one wait state, then read data and write effect together.
    // -----------------------------------------------------------------------
    always_comb
    begin
        next_waitrequest = ~((read | write) & waitrequest);
        next_readdata    = 32'h0000_0000;
        // Unmapped indices read as zero; reserved bits read as zero.
        case (idx)
            `IRQ_IDX_EN_LO:   next_readdata[7:0] = enables[7:0];        // R15
            `IRQ_IDX_EN_HI:   next_readdata[7:0] = enables[15:8];       // R15
            `IRQ_IDX_PEND_LO: next_readdata[7:0] = {pending_latch[7:2], 2'b00};  // R10 R11
            `IRQ_IDX_PEND_HI: next_readdata[7:0] = pending_latch[15:8]; // R10 R11
            `IRQ_IDX_STATUS:  next_readdata[7:0] = {idle_state, nmi_active, state[2],
                                                    1'b0, cpu_req.level};
            default:          next_readdata[7:0] = 8'h00;
        endcase
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            waitrequest <= 1'b1;
            readdata    <= 32'h0000_0000;
        end
        else
        begin
            waitrequest <= next_waitrequest;
            readdata    <= next_readdata;
        end
    end

    // -----------------------------------------------------------------------
    // Latches and enables. A source event in the same cycle as a clear by
    // software or by acceptance wins, so no request is ever lost.
    // -----------------------------------------------------------------------
    always_comb
    begin
        next_pending_latch      = pending_latch;
        next_master_enable_flag = master_enable_flag;
        next_source_enable_flag = source_enable_flag;
        next_boot_pending       = boot_pending;
        next_nmi_active         = nmi_active;
        next_imf_saved          = imf_saved;
        // Writes of zero clear, ones keep; no write can set a latch.
        if (wr_take && idx == `IRQ_IDX_PEND_LO)
        begin
            next_pending_latch[7:2] = pending_latch[7:2] & writedata[7:2];  // R9 R12
        end
        if (wr_take && idx == `IRQ_IDX_PEND_HI)
        begin
            next_pending_latch[15:8] = pending_latch[15:8] & writedata[7:0];  // R9
        end
        // Enable word is plain storage, so bit operations work on it.
        if (wr_take && idx == `IRQ_IDX_EN_LO)
        begin
            next_master_enable_flag = writedata[`IRQ_IMF_BIT];  // R15 R18
            next_source_enable_flag[7:4] = writedata[7:4];
        end
        if (wr_take && idx == `IRQ_IDX_EN_HI)
        begin
            next_source_enable_flag[15:8] = writedata[7:0];  // R15
        end
        // Return instructions restore the master enable.
        if (cpu_rsp.ret_maskable)
        begin
            next_master_enable_flag = 1'b1;
        end
        if (cpu_rsp.ret_nmi)
        begin
            next_master_enable_flag = imf_saved;
            next_nmi_active         = 1'b0;
        end
        // Acceptance clears the source latch and the master enable, which blocks further maskable requests.
        if (take_accept)
        begin
            next_master_enable_flag = 1'b0;  // R19
            if (cpu_req.level >= `IRQ_LVL_WDOG)
            begin
                next_pending_latch[cpu_req.level] = 1'b0;  // R3 R22
            end
            if (cpu_req.level == `IRQ_LVL_BOOT)
            begin
                next_boot_pending = 1'b0;
            end
            else if (cpu_req.level <= `IRQ_LVL_WDOG)
            begin
                next_nmi_active = 1'b1;  // R14
                next_imf_saved  = master_enable_flag;
            end
        end
        // Source events set last so that they beat any clear.
        next_pending_latch = next_pending_latch | src_pulse;  // R1 R3
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            pending_latch      <= 14'(`IRQ_PEND_RST >> `IRQ_LATCH_LSB);  // R4 R5
            master_enable_flag <= 1'(`IRQ_EN_RST >> `IRQ_IMF_BIT);      // R18
            source_enable_flag <= 12'(`IRQ_EN_RST >> `IRQ_EF_LSB);
            boot_pending       <= 1'b1;
            nmi_active         <= 1'b0;
            imf_saved          <= 1'b0;
        end
        else
        begin
            pending_latch      <= next_pending_latch;
            master_enable_flag <= next_master_enable_flag;
            source_enable_flag <= next_source_enable_flag;
            boot_pending       <= next_boot_pending;
            nmi_active         <= next_nmi_active;
            imf_saved          <= next_imf_saved;
        end
    end

    // -----------------------------------------------------------------------
    // Acceptance sequencer. The winner is frozen at the end of an instruction
    // and offered after the fixed acceptance time; a later, higher request
    // waits for the next instruction boundary, as on the original core.
    // -----------------------------------------------------------------------
    always_comb
    begin
        next_state   = state;
        next_cpu_req = cpu_req;
        next_mdiv    = mtick ? 8'h00 : mdiv + 8'h01;
        next_mcount  = mcount;
        case (state)
            ST_WAIT:
            begin
                if (cpu_rsp.insn_end && any_win)
                begin
                    next_state         = ST_SEQ;
                    next_cpu_req.level = win_level;  // R6
                    next_mdiv          = 8'h00;
                    next_mcount        = 8'h00;
                end
            end
            ST_SEQ:
            begin
                if (mtick)
                begin
                    next_mcount = mcount + 8'h01;
                    if (mcount == 8'(ACCEPT_MCYC - 1))
                    begin
                        next_state          = ST_OFFER;  // R20
                        next_cpu_req.req    = 1'b1;      // R22
                        next_cpu_req.vector = vector_of(cpu_req.level);  // R7
                    end
                end
            end
            ST_OFFER:
            begin
                if (cpu_rsp.accept)
                begin
                    next_state       = ST_WAIT;
                    next_cpu_req.req = 1'b0;
                end
            end
            default:
            begin
                next_state   = ST_WAIT;
                next_cpu_req = '0;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            state   <= ST_WAIT;
            cpu_req <= '0;
            mdiv    <= 8'h00;
            mcount  <= 8'h00;
        end
        else
        begin
            state   <= next_state;
            cpu_req <= next_cpu_req;
            mdiv    <= next_mdiv;
            mcount  <= next_mcount;
        end
    end

    // -----------------------------------------------------------------------
    // Idle state. Entry is refused while a watchdog request waits, because
    // the watchdog is halted in idle and could never wake the core.
    // -----------------------------------------------------------------------
    always_comb
    begin
        next_idle_state = idle_state;
        if (idle_state && wake)
        begin
            next_idle_state = 1'b0;  // R16
        end
        else if (cpu_rsp.idle_enter && !pending_latch[`IRQ_LVL_WDOG] && !wake)
        begin
            next_idle_state = 1'b1;  // R17
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            idle_state <= 1'b0;
        end
        else
        begin
            idle_state <= next_idle_state;
        end
    end

    // -----------------------------------------------------------------------
    // Checks.
    // -----------------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    logic [15:0] seq_clocks;  // Clocks since the winner was frozen.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            seq_clocks <= 16'h0000;
        end
        else
        begin
            seq_clocks <= (state == ST_WAIT) ? 16'h0000 : seq_clocks + 16'h0001;
        end
    end

    a_accept_clears_latch: assert property ( // R3
        take_accept && cpu_req.level >= 4'h2 && !src_pulse[cpu_req.level]
        |=> !pending_latch[$past(cpu_req.level)])
        else $error("accepted latch not cleared");
    a_write_never_sets: assert property ( // R9
        (src_pulse == 14'h0000) |=> (pending_latch & ~$past(pending_latch)) == 14'h0000)
        else $error("latch set without a source event");
    a_mask_gating: assert property ( // R8
        state == ST_WAIT && next_state == ST_SEQ && win_level >= 4'h4
        |-> master_enable_flag && source_enable_flag[win_level])
        else $error("masked source selected");
    a_imf_on_accept: assert property ( // R19
        take_accept && !cpu_rsp.ret_maskable && !cpu_rsp.ret_nmi |=> !master_enable_flag)
        else $error("master enable kept after acceptance");
    a_nmi_no_nest: assert property ( // R14
        nmi_active && state == ST_WAIT && next_state == ST_SEQ
        |-> win_level != 4'h1 && win_level != 4'h2)
        else $error("pseudo non-maskable service nested");
    a_accept_latency: assert property ( // R20
        $rose(cpu_req.req) |-> seq_clocks == 16'(ACCEPT_MCYC * MCYC_CLKS))
        else $error("acceptance time wrong");
    a_vector_level: assert property ( // R7
        cpu_req.req |-> cpu_req.vector == 16'hFFFE - {11'h000, cpu_req.level, 1'b0})
        else $error("vector does not match level");
    a_idle_wdog_block: assert property ( // R17
        !idle_state && cpu_rsp.idle_enter && pending_latch[2] |=> !idle_state)
        else $error("idle entered with watchdog pending");
    a_offer_holds: assert property ( // R22
        cpu_req.req && !cpu_rsp.accept |=> cpu_req.req && $stable(cpu_req.vector))
        else $error("request dropped before accept");

    c_maskable_served: cover property (take_accept && cpu_req.level >= 4'h4);
    c_nmi_served: cover property (take_accept && cpu_req.level == 4'h2);
    c_idle_wake: cover property (idle_state ##1 !idle_state);
    c_latch_cleared: cover property (wr_take && idx == 6'h3C);

endmodule : irq_controller

// ---- irq_ctrl_consts.svh ----
// Constants for the prioritized interrupt controller: offsets, fields, resets, timing.
//
// Functional notes
// R1: Fifteen sources, six external, nine internal, own vectors.
// R2: Software trap and watchdog are pseudo non-maskable.
// R3: Latch sets on request, clears after acceptance.
// R4: Reset forces every request latch to zero.
// R5: No trap latch; latches only at 2..15.
// R6: Fixed priority, reset 0 down to ext5 15.
// R7: Vector is top word minus two per level.
// R8: Maskable accepted only with master and own enable.
// R9: Write clears latch on zero, one leaves it.
// R10: Software reads all request latches for polling.
// R11: Latches mapped as low byte, then high byte.
// R12: Software clears latches whole-register, never watchdog latch; here a zero in bit 2 clears it.
// R13: Pseudo non-maskables ignore master and own enables.
// R14: Pseudo non-maskable services never nest.
// R15: Enable word at two addresses, fully read/write.
// R16: Enabled source or ext0 request ends idle.
// R17: Watchdog pending at idle entry blocks idle.
// R18: Master enable is bit zero, reset clears it.
// R19: Accepting maskable request clears master enable.
// R20: Acceptance takes eight machine cycles after instruction.
// R21: Ext0 gated by master enable and gate bit.
// R22: Request and vector out, accept pulse clears.
`ifndef IRQ_CTRL_CONSTS_SVH
`define IRQ_CTRL_CONSTS_SVH

// ---------------------------------------------------------------------------
// Register indices; the byte address is four times the index.
// ---------------------------------------------------------------------------
`define IRQ_IDX_EN_LO    6'h3A
`define IRQ_IDX_EN_HI    6'h3B
`define IRQ_IDX_PEND_LO  6'h3C
`define IRQ_IDX_PEND_HI  6'h3D
`define IRQ_IDX_STATUS   6'h3E

// ---------------------------------------------------------------------------
// Field positions and reset values.
// ---------------------------------------------------------------------------
`define IRQ_IMF_BIT      0
`define IRQ_EF_LSB       4
`define IRQ_LATCH_LSB    2
`define IRQ_LVL_BOOT     4'h0
`define IRQ_LVL_TRAP     4'h1
`define IRQ_LVL_WDOG     4'h2
`define IRQ_LVL_EXT0     4'h3
`define IRQ_PEND_RST     16'h0000
`define IRQ_EN_RST       16'h0000
`define IRQ_VEC_TOP      16'hFFFE

// ---------------------------------------------------------------------------
// Timing: clocks per machine cycle and machine cycles per acceptance.
// ---------------------------------------------------------------------------
`define IRQ_MCYC_CLKS    4
`define IRQ_ACCEPT_MCYC  8

`endif

// ---- irq_ctrl_pkg.sv ----
// Types and shared helpers for the prioritized interrupt controller.
package irq_ctrl_pkg;

`include "irq_ctrl_consts.svh"

    // -----------------------------------------------------------------------
    // Acceptance sequencer states, one-hot.
    // -----------------------------------------------------------------------
    typedef enum logic [2:0]
    {
        ST_WAIT  = 3'b001,
        ST_SEQ   = 3'b010,
        ST_OFFER = 3'b100
    } seq_state_t;

    // Request offered to the CPU core.
    typedef struct packed
    {
        logic        req;
        logic [15:0] vector;
        logic [3:0]  level;
    } cpu_req_t;

    // Strobes coming back from the CPU core, all one-cycle pulses but sw_trap.
    typedef struct packed
    {
        logic insn_end;
        logic accept;
        logic ret_maskable;
        logic ret_nmi;
        logic idle_enter;
        logic sw_trap;
    } cpu_rsp_t;

    // Vector table entry for a priority level.
    function automatic logic [15:0] vector_of(input logic [3:0] lvl);
        return `IRQ_VEC_TOP - {11'h000, lvl, 1'b0};
    endfunction : vector_of

endpackage : irq_ctrl_pkg

// ---- irq_priority_pick.sv ----
// Eligibility gating, fixed-priority selection and idle wake detection.
`timescale 1ns/100ps
`include "irq_ctrl_consts.svh"
module irq_priority_pick
(
    // Request state.
    input  wire logic [15:0] pend_all,
    input  wire logic [15:0] enables,
    input  wire logic        ext0_gate_bit,
    input  wire logic        nmi_active,
    // Selection results.
    output logic             any_win,
    output logic [3:0]       win_level,
    output logic             wake
);
    import irq_ctrl_pkg::*;

    logic [15:0] eligible;  // Requests that may be accepted now.

    // -----------------------------------------------------------------------
    // Gating of every level but boot by its enable condition.
    // -----------------------------------------------------------------------
    always_comb
    begin
        eligible    = 16'h0000;
        eligible[0] = pend_all[0];
        // Trap and watchdog skip the enables, but never nest.
        eligible[1] = pend_all[1] & ~nmi_active;  // R2 R13 R14
        eligible[2] = pend_all[2] & ~nmi_active;  // R13 R14
        // Ext0 has no own enable flag, only its gate bit.
        eligible[3] = pend_all[3] & enables[`IRQ_IMF_BIT] & ext0_gate_bit;  // R21
        for (int i = `IRQ_EF_LSB; i < 16; i++)
        begin
            eligible[i] = pend_all[i] & enables[`IRQ_IMF_BIT] & enables[i];  // R8
        end
    end

    // -----------------------------------------------------------------------
    // Lowest level number wins; the loop runs downward so it is assigned last.
    // -----------------------------------------------------------------------
    always_comb
    begin
        any_win   = |eligible;
        win_level = 4'h0;
        for (int i = 15; i >= 0; i--)
        begin
            if (eligible[i])
            begin
                win_level = 4'(i);  // R6
            end
        end
    end

    // Idle ends on any individually enabled source or an ext0 request.
    always_comb
    begin
        wake = pend_all[3] | (|(pend_all[15:4] & enables[15:4]));  // R16
    end

endmodule : irq_priority_pick

// ---- prioritized_interrupt_controller_tb_top.sv ----
// Self-checking bench for the interrupt controller.
`timescale 1ns/100ps
module prioritized_interrupt_controller_tb_top;
    import irq_ctrl_pkg::*;
    logic mclk = 0, rst = 1, read = 0, write = 0, gate = 0, go = 1, trap = 0;
    logic [7:0] address = 8'h00;
    logic [31:0] writedata = 32'h0000_0000, readdata;
    logic waitrequest, idle_state;
    logic [15:2] src = '0;
    logic [2:0] ctl = '0;
    logic [7:0] q;
    logic [15:0] last_vec;
    int acc_n, n0, failures = 0, check_count = 0;
    cpu_req_t cpu_req;
    cpu_rsp_t cpu_rsp;
    // Short machine cycle keeps each acceptance at eight clocks.
    irq_controller #(.MCYC_CLKS(1), .ACCEPT_MCYC(8)) DUT (.mclk(mclk), .rst(rst),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .byteenable(4'h1), .readdata(readdata), .waitrequest(waitrequest),
        .src_pulse(src), .ext0_gate_bit(gate), .cpu_rsp(cpu_rsp), .cpu_req(cpu_req),
        .idle_state(idle_state));
    cpu_core_model cpu (.mclk(mclk), .rst(rst), .go(go), .ctl(ctl), .trap(trap),
        .req_in(cpu_req), .rsp(cpu_rsp), .last_vec(last_vec), .acc_n(acc_n));
    always #5 mclk = ~mclk;
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        check_count++;
        if (s !== e)
        begin
            failures++;
            $display("BAD %0t seen %h want %h", $time, s, e);
        end
    endtask : chk
    // One bus access; held until waitrequest is sampled low.
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        write <= w;
        read <= !w;
        address <= a;
        writedata <= {24'h00_0000, d};
        do
        begin
            @(posedge mclk);
        end
        while (waitrequest !== 1'b0);
        q = readdata[7:0];
        write <= 1'b0;
        read <= 1'b0;
        @(posedge mclk);
    endtask : bus
    task automatic fire(input logic [15:0] b);
        src <= b[15:2];
        @(posedge mclk);
        src <= '0;
        @(posedge mclk);
    endtask : fire
    task automatic strobe(input logic [2:0] b);
        ctl <= b;
        @(posedge mclk);
        ctl <= '0;
        @(posedge mclk);
    endtask : strobe
    // Waits for the next acceptance, then checks the vector taken.
    task automatic took(input logic [15:0] v);
        n0 = acc_n;
        while (acc_n == n0)
        begin
            @(posedge mclk);
        end
        chk(last_vec, v);
    endtask : took
    task automatic t_reset;
        took(16'hFFFE);
        bus(0, 8'hE8, 0); chk(q, 8'h00);
        bus(0, 8'hF0, 0); chk(q, 8'h00);
    endtask : t_reset
    task automatic t_regs;
        bus(1, 8'hEC, 8'hA5); bus(0, 8'hEC, 0); chk(q, 8'hA5);
        bus(0, 8'h00, 0); chk(q, 8'h00);
        bus(1, 8'hEC, 8'h00);
    endtask : t_regs
    task automatic t_latch;
        go <= 1'b0;
        fire(16'h1030);
        bus(0, 8'hF0, 0); chk(q, 8'h30);
        bus(0, 8'hF4, 0); chk(q, 8'h10);
        bus(1, 8'hF0, 8'hEF); bus(0, 8'hF0, 0); chk(q, 8'h20);
        bus(1, 8'hF4, 8'h00); bus(0, 8'hF4, 0); chk(q, 8'h00);
    endtask : t_latch
    // Levels 5 and 7 pending together; master enable gates the second one.
    task automatic t_prio;
        fire(16'h0080);
        bus(1, 8'hE8, 8'hA1);
        go <= 1'b1;
        took(16'hFFF4);
        bus(0, 8'hE8, 0); chk(q, 8'hA0);
        bus(0, 8'hF0, 0); chk(q, 8'h80);
        strobe(3'b001);
        took(16'hFFF0);
    endtask : t_prio
    // Trap service blocks the watchdog until its return.
    task automatic t_nmi;
        trap <= 1'b1;
        took(16'hFFFC);
        trap <= 1'b0;
        fire(16'h0004);
        repeat (30) @(posedge mclk);
        chk(16'(acc_n - n0), 16'h0001);
        strobe(3'b010);
        took(16'hFFFA);
        strobe(3'b010);
        gate <= 1'b1;
        bus(1, 8'hE8, 8'h01);
        fire(16'h0008);
        took(16'hFFF8);
    endtask : t_nmi
    task automatic t_idle;
        go <= 1'b0;
        bus(1, 8'hE8, 8'h10);
        strobe(3'b100); chk(idle_state, 1'b1);
        bus(0, 8'hF8, 0); chk(q, 8'h83);
        fire(16'h0010);
        repeat (2) @(posedge mclk);
        chk(idle_state, 1'b0);
        bus(1, 8'hF0, 8'h04);
        fire(16'h0004);
        strobe(3'b100); chk(idle_state, 1'b0);
        go <= 1'b1;
        took(16'hFFFA);
    endtask : t_idle
    task automatic tally_and_finish;
        if (failures == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        t_reset;
        t_regs;
        t_latch;
        t_prio;
        t_nmi;
        t_idle;
        tally_and_finish;
    end
    // Whole run is a few hundred clocks; this limit only catches a hang.
    initial
    begin
        #50000;
        failures++;
        tally_and_finish;
    end
endmodule : prioritized_interrupt_controller_tb_top
